/* File: core/rtc_alarm.sv */
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module rtc_alarm
	import rtc_alarm_pkg::*;
#(
	parameter int ADDR_W = 4
)(
	input  wire logic        clk,            // 25 MHz clock
	input  wire logic        arst_n,         // Async reset, active low
	input  wire logic        half_sec_tick,  // Pulse each half second
	input  wire logic        sec_tick,       // Pulse when time below advances
	input  wire logic [7:0]  now_sec,        // BCD seconds
	input  wire logic [7:0]  now_min,        // BCD minutes
	input  wire logic [7:0]  now_hour,       // BCD hours
	input  wire logic [7:0]  now_wday,       // Weekday
	input  wire logic [7:0]  now_mday,       // BCD day of month
	input  wire logic [7:0]  now_month,      // BCD month
	output logic             alarm_event,    // One-cycle alarm pulse
	input  wire logic [ADDR_W-1:0] awaddr,   // Write address
	input  wire logic        awvalid,        // Write address valid
	output logic             awready,        // Write address ready
	input  wire logic [31:0] wdata,          // Write data
	input  wire logic [3:0]  wstrb,          // Write byte strobes
	input  wire logic        wvalid,         // Write data valid
	output logic             wready,         // Write data ready
	output logic [1:0]       bresp,          // Write response
	output logic             bvalid,         // Write response valid
	input  wire logic        bready,         // Write response ready
	input  wire logic [ADDR_W-1:0] araddr,   // Read address
	input  wire logic        arvalid,        // Read address valid
	output logic             arready,        // Read address ready
	output logic [31:0]      rdata,          // Read data
	output logic [1:0]       rresp,          // Read response
	output logic             rvalid,         // Read data valid
	input  wire logic        rready          // Read data ready
);

	// Refuse address widths too small for the map
	if (ADDR_W < 3)
	begin : g_bad_addr
		$error("ADDR_W must be at least 3");
	end

	// Offset compare on byte address
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] off);
		hit = (a == ADDR_W'(off)) ? 1'b1 : 1'b0;
	endfunction

	// Saturating pointer step-down
	function automatic logic [1:0] ptr_dec(input logic [1:0] p, input logic [1:0] n);
		ptr_dec = (p > n) ? p - n : PTR_ZERO;
	endfunction

	chan_state_t       wr_st_r;
	chan_state_t       rd_st_r;
	logic              aw_full_r;
	logic              w_full_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic [31:0]       w_data_r;
	logic [3:0]        w_strb_r;
	logic              en_r;
	logic              chime_r;
	logic [3:0]        ival_r;
	logic [1:0]        ptr_r;
	logic [7:0]        rpt_r;
	logic [7:0]        hi_r [0:2];
	logic [7:0]        lo_r [0:2];
	logic              wr_go;
	logic              rd_go;
	logic              cfg_wr;
	logic              win_wr;
	logic              win_rd;
	logic              match;
	logic              evt;
	logic [1:0]        ptr_steps;
	logic [15:0]       setup_view;
	logic [15:0]       win_view;

	// Write performs once both address and data are held
	assign wr_go  = aw_full_r && w_full_r && (wr_st_r == CH_IDLE);
	assign rd_go  = arvalid && arready;
	assign cfg_wr = wr_go && hit(aw_addr_r, OFF_SETUP);
	assign win_wr = wr_go && hit(aw_addr_r, OFF_WINDOW);
	assign win_rd = rd_go && hit(araddr, OFF_WINDOW);

	// Register views
	assign setup_view = {en_r, chime_r, ival_r, ptr_r, rpt_r};
	assign win_view   = (ptr_r == PTR_UNIMP) ? 16'h0000 : {hi_r[ptr_r], lo_r[ptr_r]};

	// Field compare by interval select, time fields in BCD
	always_comb
	begin
		match = 1'b0;
		case (ival_r)
			IV_HALF_SEC: match = half_sec_tick;
			IV_SEC:      match = sec_tick;
			IV_TEN_SEC:  match = sec_tick && (now_sec[3:0] == lo_r[0][3:0]);
			IV_MIN:      match = sec_tick && (now_sec == lo_r[0]);
			IV_TEN_MIN:  match = sec_tick && (now_sec == lo_r[0])
				&& (now_min[3:0] == hi_r[0][3:0]);
			IV_HOUR:     match = sec_tick && (now_sec == lo_r[0]) && (now_min == hi_r[0]);
			IV_DAY:      match = sec_tick && (now_sec == lo_r[0]) && (now_min == hi_r[0])
				&& (now_hour == lo_r[1]);
			IV_WEEK:     match = sec_tick && (now_sec == lo_r[0]) && (now_min == hi_r[0])
				&& (now_hour == lo_r[1]) && (now_wday == hi_r[1]);
			IV_MONTH:    match = sec_tick && (now_sec == lo_r[0]) && (now_min == hi_r[0])
				&& (now_hour == lo_r[1]) && (now_mday == lo_r[2]);
			// 29 Feb only matches in a year that has it
			IV_YEAR:     match = sec_tick && (now_sec == lo_r[0]) && (now_min == hi_r[0])
				&& (now_hour == lo_r[1]) && (now_mday == lo_r[2])
				&& (now_month == hi_r[2]);
			default:     match = 1'b0;
		endcase
	end

	assign evt = en_r && match;

	// Event output pulse
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			alarm_event <= 1'b0;
		else
			alarm_event <= evt;
	end

	// Enable, chime and interval byte; a write wins over the self-clear
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			en_r    <= SETUP_RST[EN_BIT];
			chime_r <= SETUP_RST[CHIME_BIT];
			ival_r  <= SETUP_RST[MASK_HI:MASK_LO];
		end
		else if (cfg_wr && w_strb_r[1])
		begin
			en_r    <= w_data_r[EN_BIT];
			chime_r <= w_data_r[CHIME_BIT];
			ival_r  <= w_data_r[MASK_HI:MASK_LO];
		end
		else if (evt && (rpt_r == RPT_ZERO) && !chime_r)
			en_r <= 1'b0;
	end

	// Repeat count
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			rpt_r <= SETUP_RST[RPT_HI:RPT_LO];
		else if (cfg_wr && w_strb_r[0])
			rpt_r <= w_data_r[RPT_HI:RPT_LO];
		else if (evt)
		begin
			if (rpt_r != RPT_ZERO)
				rpt_r <= rpt_r - 8'h01;
			else if (chime_r)
				rpt_r <= RPT_FULL;
			else
				rpt_r <= RPT_ZERO;
		end
	end

	// Window reads and high-lane window writes counted this cycle
	assign ptr_steps = {1'b0, win_rd} + {1'b0, win_wr && w_strb_r[WIN_HI_LANE]};

	// Window pointer
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			ptr_r <= SETUP_RST[PTR_HI:PTR_LO];
		else if (cfg_wr && w_strb_r[1])
			ptr_r <= w_data_r[PTR_HI:PTR_LO];
		else
			ptr_r <= ptr_dec(ptr_r, ptr_steps);
	end

	// Alarm value bytes behind the window
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hi_r <= '{VAL_RST, VAL_RST, VAL_RST};
			lo_r <= '{VAL_RST, VAL_RST, VAL_RST};
		end
		else if (win_wr && (ptr_r != PTR_UNIMP))
		begin
			if (w_strb_r[WIN_HI_LANE])
				hi_r[ptr_r] <= w_data_r[15:8];
			if (w_strb_r[WIN_LO_LANE])
				lo_r[ptr_r] <= w_data_r[7:0];
		end
	end

	// Write address and data capture, either order
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			awready   <= 1'b1;
			wready    <= 1'b1;
			aw_full_r <= 1'b0;
			w_full_r  <= 1'b0;
			aw_addr_r <= '0;
			w_data_r  <= 32'h00000000;
			w_strb_r  <= 4'h0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_addr_r <= awaddr;
				aw_full_r <= 1'b1;
				awready   <= 1'b0;
			end
			else if (wr_go)
				aw_full_r <= 1'b0;
			if (wvalid && wready)
			begin
				w_data_r <= wdata;
				w_strb_r <= wstrb;
				w_full_r <= 1'b1;
				wready   <= 1'b0;
			end
			else if (wr_go)
				w_full_r <= 1'b0;
			if (bvalid && bready)
			begin
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// Write response
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wr_st_r <= CH_IDLE;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
		end
		else
		begin
			case (wr_st_r)
				CH_IDLE:
					if (wr_go)
					begin
						wr_st_r <= CH_BUSY;
						bvalid  <= 1'b1;
						bresp   <= (hit(aw_addr_r, OFF_SETUP) || hit(aw_addr_r, OFF_WINDOW))
							? RESP_OKAY : RESP_SLVERR;
					end
				CH_BUSY:
					if (bready)
					begin
						wr_st_r <= CH_IDLE;
						bvalid  <= 1'b0;
					end
				default:
					wr_st_r <= CH_IDLE;
			endcase
		end
	end

	// Read channel
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rd_st_r <= CH_IDLE;
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= RESP_OKAY;
		end
		else
		begin
			case (rd_st_r)
				CH_IDLE:
					if (rd_go)
					begin
						rd_st_r <= CH_BUSY;
						arready <= 1'b0;
						rvalid  <= 1'b1;
						rresp   <= RESP_OKAY;
						if (hit(araddr, OFF_SETUP))
							rdata <= {16'h0000, setup_view};
						else if (hit(araddr, OFF_WINDOW))
							rdata <= {16'h0000, win_view};
						else
						begin
							rdata <= 32'h00000000;
							rresp <= RESP_SLVERR;
						end
					end
				CH_BUSY:
					if (rready)
					begin
						rd_st_r <= CH_IDLE;
						arready <= 1'b1;
						rvalid  <= 1'b0;
					end
				default:
					rd_st_r <= CH_IDLE;
			endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_last_event;
		evt && (rpt_r == RPT_ZERO) && !(cfg_wr && |w_strb_r[1:0]);
	endsequence

	a_enable_self_clear: assert property (
		s_last_event and !chime_r |=> !en_r && alarm_event ##1 !alarm_event)
		else $error("alarm enable not cleared after final event");
	a_chime_wrap: assert property (
		s_last_event and chime_r |=> rpt_r == RPT_FULL && en_r)
		else $error("repeat count did not wrap under chime");
	a_count_hold: assert property (
		s_last_event and !chime_r |=> rpt_r == RPT_ZERO)
		else $error("repeat count moved below zero");
	a_count_step: assert property (
		evt && (rpt_r != RPT_ZERO) && !(cfg_wr && w_strb_r[0])
		|=> rpt_r == $past(rpt_r) - 8'h01)
		else $error("repeat count did not step down by one");
	a_count_idle: assert property (
		!evt && !cfg_wr |=> $stable(rpt_r))
		else $error("repeat count changed without an event");
	a_ptr_step: assert property (
		win_rd && !win_wr && !cfg_wr && (ptr_r != PTR_ZERO)
		|=> ptr_r == $past(ptr_r) - 2'h1)
		else $error("pointer did not step on window read");
	a_ptr_floor: assert property (
		(ptr_r == PTR_ZERO) && !cfg_wr |=> ptr_r == PTR_ZERO)
		else $error("pointer moved below zero");
	a_reserved_quiet: assert property (
		(ival_r > IV_YEAR) |=> !alarm_event)
		else $error("event under reserved interval code");
	a_event_pulse: assert property (
		evt |=> alarm_event ##1 (alarm_event == $past(evt)))
		else $error("alarm event output did not follow match");
	a_window_read: assert property (
		win_rd && (ptr_r == PTR_UNIMP) |=> rvalid && rdata == 32'h00000000)
		else $error("unimplemented window slot not read as zero");
	a_write_answer: assert property (
		wr_go |=> bvalid [*1] ##0 !awready)
		else $error("write response missing");

endmodule

/* File: pkg/rtc_alarm_pkg.sv */
package rtc_alarm_pkg;

	// Register byte offsets
	localparam logic [3:0] OFF_SETUP  = 4'h0;
	localparam logic [3:0] OFF_WINDOW = 4'h4;

	// Setup register field positions
	localparam int EN_BIT    = 15;
	localparam int CHIME_BIT = 14;
	localparam int MASK_HI   = 13;
	localparam int MASK_LO   = 10;
	localparam int PTR_HI    = 9;
	localparam int PTR_LO    = 8;
	localparam int RPT_HI    = 7;
	localparam int RPT_LO    = 0;

	// Window register byte lanes
	localparam int WIN_HI_LANE = 1;
	localparam int WIN_LO_LANE = 0;

	// Reset values
	localparam logic [15:0] SETUP_RST = 16'h0000;
	localparam logic [7:0]  VAL_RST   = 8'h00;

	// Repeat counter limits
	localparam logic [7:0] RPT_ZERO = 8'h00;
	localparam logic [7:0] RPT_FULL = 8'hFF;

	// Pointer limits
	localparam logic [1:0] PTR_ZERO  = 2'h0;
	localparam logic [1:0] PTR_UNIMP = 2'h3;

	// Interval select codes
	localparam logic [3:0] IV_HALF_SEC = 4'h0;
	localparam logic [3:0] IV_SEC      = 4'h1;
	localparam logic [3:0] IV_TEN_SEC  = 4'h2;
	localparam logic [3:0] IV_MIN      = 4'h3;
	localparam logic [3:0] IV_TEN_MIN  = 4'h4;
	localparam logic [3:0] IV_HOUR     = 4'h5;
	localparam logic [3:0] IV_DAY      = 4'h6;
	localparam logic [3:0] IV_WEEK     = 4'h7;
	localparam logic [3:0] IV_MONTH    = 4'h8;
	localparam logic [3:0] IV_YEAR     = 4'h9;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Bus handshake states
	typedef enum logic [1:0] {
		CH_IDLE = 2'b01,
		CH_BUSY = 2'b10
	} chan_state_t;

endpackage

/* File: test/rtc_alarm_tb_top.sv */
`timescale 1ns/1ps
module rtc_alarm_tb_top;
	import rtc_alarm_pkg::*;

	logic        clk, arst_n, half_sec_tick, sec_tick, alarm_event;
	logic [7:0]  now_sec, now_min, now_hour, now_wday, now_mday, now_month;
	logic [3:0]  awaddr, araddr, wstrb, c;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	int          error_cnt, n_tests, ev_cnt, i;

	rtc_alarm #(.ADDR_W(4)) i_rtc_alarm (
		.clk, .arst_n, .half_sec_tick, .sec_tick, .now_sec, .now_min, .now_hour,
		.now_wday, .now_mday, .now_month, .alarm_event, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready
	);

	// Clock source
	always #20 clk = ~clk;

	// Alarm pulse counter
	always @(posedge clk)
		if (alarm_event === 1'b1)
			ev_cnt <= ev_cnt + 1;

	// Verdict and end of run
	task test_done();
		if (error_cnt == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Compare and report
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Bus write with response check
	task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int k = 0; k < 20 && !done; k++)
		begin
			@(posedge clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid === 1'b1)
			begin
				done = 1'b1;
				bready <= 1'b0;
				chk({30'h0, bresp}, {30'h0, er});
			end
		end
		if (!done)
		begin
			chk(32'h0, 32'h1);
			test_done();
		end
	endtask

	// Bus read with data and response check
	task rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int k = 0; k < 20 && !done; k++)
		begin
			@(posedge clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid === 1'b1)
			begin
				done = 1'b1;
				rready <= 1'b0;
				chk(rdata, exp);
				chk({30'h0, rresp}, {30'h0, er});
			end
		end
		if (!done)
		begin
			chk(32'h0, 32'h1);
			test_done();
		end
	endtask

	// One tick pulse, then count alarm pulses
	task pulse(input logic half, input int exp_n);
		int n0;
		n0 = ev_cnt;
		@(posedge clk);
		if (half)
			half_sec_tick <= 1'b1;
		else
			sec_tick <= 1'b1;
		@(posedge clk);
		half_sec_tick <= 1'b0;
		sec_tick <= 1'b0;
		repeat (3) @(posedge clk);
		chk(32'(ev_cnt - n0), 32'(exp_n));
	endtask

	// Time equal to the stored alarm fields
	task set_now();
		now_sec <= 8'h34;
		now_min <= 8'h12;
		now_hour <= 8'h05;
		now_wday <= 8'h03;
		now_mday <= 8'h29;
		now_month <= 8'h02;
	endtask

	// Main sequence
	initial
	begin
		clk = 1'b0;
		arst_n = 1'b0;
		{half_sec_tick, sec_tick, awvalid, wvalid, bready, arvalid, rready} = '0;
		{now_sec, now_min, now_hour, now_wday, now_mday, now_month} = '0;
		{awaddr, araddr, wstrb, wdata} = '0;
		error_cnt = 0;
		n_tests = 0;
		ev_cnt = 0;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		rd(OFF_SETUP, 32'h0, RESP_OKAY);
		rd(OFF_WINDOW, 32'h0, RESP_OKAY);
		wr(OFF_SETUP, 32'h1234_66A5, 4'hF, RESP_OKAY);
		rd(OFF_SETUP, 32'h0000_66A5, RESP_OKAY);
		wr(4'h8, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
		rd(4'h8, 32'h0, RESP_SLVERR);
		// Fill the slots through the window, pointer walking down
		wr(OFF_WINDOW, 32'h0000_0229, 4'h3, RESP_OKAY);
		rd(OFF_SETUP, 32'h0000_65A5, RESP_OKAY);
		wr(OFF_WINDOW, 32'h0000_0305, 4'h3, RESP_OKAY);
		wr(OFF_WINDOW, 32'h0000_1234, 4'h3, RESP_OKAY);
		rd(OFF_SETUP, 32'h0000_64A5, RESP_OKAY);
		// Read back from the unimplemented slot down to zero
		wr(OFF_SETUP, 32'h0000_67A5, 4'h3, RESP_OKAY);
		rd(OFF_WINDOW, 32'h0, RESP_OKAY);
		rd(OFF_WINDOW, 32'h0000_0229, RESP_OKAY);
		rd(OFF_WINDOW, 32'h0000_0305, RESP_OKAY);
		rd(OFF_WINDOW, 32'h0000_1234, RESP_OKAY);
		rd(OFF_WINDOW, 32'h0000_1234, RESP_OKAY);
		rd(OFF_SETUP, 32'h0000_64A5, RESP_OKAY);
		// Count down without chime, enable clears at the end
		wr(OFF_SETUP, 32'h0000_8402, 4'h3, RESP_OKAY);
		for (i = 0; i < 3; i++)
		begin
			pulse(1'b0, 1);
			rd(OFF_SETUP, (i < 2) ? 32'h8401 - i : 32'h0400, RESP_OKAY);
		end
		pulse(1'b0, 0);
		// Chime lets the count wrap and keeps enable
		wr(OFF_SETUP, 32'h0000_C400, 4'h3, RESP_OKAY);
		pulse(1'b0, 1);
		rd(OFF_SETUP, 32'h0000_C4FF, RESP_OKAY);
		pulse(1'b0, 1);
		rd(OFF_SETUP, 32'h0000_C4FE, RESP_OKAY);
		wr(OFF_SETUP, 32'h0000_C0FF, 4'h3, RESP_OKAY);
		pulse(1'b1, 1);
		// Every field-matching interval: hit, then one field off
		set_now();
		for (c = 4'h2; c <= 4'h9; c++)
		begin
			wr(OFF_SETUP, {16'h0, 2'b11, c, 2'b00, 8'hFF}, 4'h3, RESP_OKAY);
			pulse(1'b0, 1);
			case (c)
				4'h2: now_sec <= 8'h35;
				4'h3: now_sec <= 8'h24;
				4'h4: now_min <= 8'h13;
				4'h5: now_min <= 8'h22;
				4'h6: now_hour <= 8'h06;
				4'h7: now_wday <= 8'h04;
				4'h8: now_mday <= 8'h28;
				default: now_month <= 8'h03;
			endcase
			pulse(1'b0, 0);
			set_now();
		end
		test_done();
	end
endmodule
